// ===== design/hcs_pkg.sv
/*
  hcs_pkg: constants for the hub configuration strap selector.
  assumes a single 200 MHz clock and synchronous strap inputs.
*/
package hcs_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned CLK_PERIOD_PS   = 5_000;
  // least reset pulse from the system, in ns, rounded up to cycles
  localparam int unsigned RESET_MIN_NS    = 1_000;
  localparam int unsigned RESET_MIN_CYC   =
    (RESET_MIN_NS * 1_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // nominal reference frequency
  localparam int unsigned REF_HZ          = 24_000_000;

  localparam logic [6:0] SMB_SLAVE_ADDR   = 7'h2C;

  localparam logic [2:0] SEL_DEFAULT_3W   = 3'h0;
  localparam logic [2:0] SEL_SMBUS        = 3'h1;
  localparam logic [2:0] SEL_DEFAULT_4WL  = 3'h2;
  localparam logic [2:0] SEL_EEPROM       = 3'h3;
  localparam logic [2:0] SEL_DEFAULT_4WE1 = 3'h4;
  localparam logic [2:0] SEL_DEFAULT_4WE2 = 3'h5;

  typedef enum logic [2:0] {
    HCS_SRC_INTERNAL = 3'b001,
    HCS_SRC_SMBUS    = 3'b010,
    HCS_SRC_EEPROM   = 3'b100
  } hcs_src_e;

  typedef enum logic [2:0] {
    HCS_PA_3WIRE     = 3'b001,
    HCS_PA_4W_LEVEL  = 3'b010,
    HCS_PA_4W_EDGE   = 3'b100
  } hcs_pa_e;

  typedef enum logic [3:0] {
    HCS_LED_USB      = 4'b0001,
    HCS_LED_SINGLE8  = 4'b0010,
    HCS_LED_DUAL8    = 4'b0100,
    HCS_LED_EXTERNAL = 4'b1000
  } hcs_led_e;

  typedef enum logic [2:0] {
    HCS_ST_RESET     = 3'b001,
    HCS_ST_LATCH     = 3'b010,
    HCS_ST_RUN       = 3'b100
  } hcs_state_e;

  localparam logic [3:0] PA_WIDTH_3W_MASK = 4'h7;
  localparam logic [3:0] PA_WIDTH_4W_MASK = 4'hF;
endpackage

// ===== design/hcs_sync_reg.sv
/*
  hcs_sync_reg: parameterised input register with enable.
  assumes inputs are already synchronous to mclk_i.
*/
`timescale 1ns/1ps
module hcs_sync_reg #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // data
  input  wire logic             en_i,
  input  wire logic [WIDTH-1:0] d_i,
  output      logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  always_comb
  begin
    q_next = q_reg;
    if (en_i)
    begin
      q_next = d_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      q_reg <= '0;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule

// ===== design/hcs_strap_select.sv
/*
  hcs_strap_select: latches config-select straps at reset release and
  derives configuration source, assignment style and LED options.
  assumes rst_i comes from the board reset (active high here) and that
  strap and assignment inputs are synchronous to mclk_i.
*/
`timescale 1ns/1ps
// Summary of operation
// - latch the three select straps at reset release, choose config method
// - select 000: internal defaults, 3-wire, LED straps sampled, USB LEDs
// - select 001: SMBus slave at 0101100, LED straps ignored
// - select 010: defaults, 4-wire level, straps sampled, no unassigned
// - select 011: load from I2C EEPROM as master on shared pins
// - select 100: 4-wire edge, 8 single LEDs, straps, unassigned allowed
// - select 101: 4-wire edge, 8 dual LEDs, no straps, unassigned allowed
// - assignment inputs act as 3-wire or 4-wire per latched select
// - local power high means self powered, low means bus powered
// - runs from a 24 MHz reference, crystal or external clock
// - one open-drain pin pair shared by EEPROM and SMBus uses
// - assignment input changes ignored while in reset
module hcs_strap_select (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // straps and board inputs
  input  wire logic       config_method_strap_bit0_i,
  input  wire logic       config_method_strap_bit1_i,
  input  wire logic       config_method_strap_bit2_i,
  input  wire logic [3:0] port_led_strap_pins_i,
  input  wire logic [3:0] port_owner_select_inputs_i,
  input  wire logic       local_power_detect_i,
  // configuration outputs
  output      logic [2:0] cfg_sel_o,
  output      logic [2:0] cfg_src_o,
  output      logic [2:0] assign_mode_o,
  output      logic [3:0] led_mode_o,
  output      logic       led_strap_en_o,
  output      logic [3:0] led_strap_o,
  output      logic       unassigned_ok_o,
  output      logic [3:0] port_assign_o,
  output      logic       self_powered_o,
  output      logic       cfg_valid_o,
  // shared serial pins role
  output      logic       serial_is_master_o,
  output      logic       serial_is_slave_o,
  output      logic [6:0] smb_addr_o
);
  hcs_pkg::hcs_state_e st_reg;
  hcs_pkg::hcs_state_e st_next;
  logic [2:0] sel_reg;
  logic [2:0] sel_next;
  logic [2:0] src_reg;
  logic [2:0] src_next;
  logic [2:0] pa_reg;
  logic [2:0] pa_next;
  logic [3:0] led_reg;
  logic [3:0] led_next;
  logic       strap_en_reg;
  logic       strap_en_next;
  logic [3:0] strap_reg;
  logic [3:0] strap_next;
  logic       ua_reg;
  logic       ua_next;
  logic       master_reg;
  logic       master_next;
  logic       slave_reg;
  logic       slave_next;
  logic       pwr_reg;
  logic       pwr_next;
  logic       valid_reg;
  logic       valid_next;
  logic [6:0] addr_reg;
  logic [6:0] addr_next;
  logic       latch_en;
  logic       run_en;
  logic [2:0] strap_sel;
  logic [2:0] eff_sel;
  logic [3:0] pa_mask;
  logic [3:0] pa_raw;

  assign strap_sel = {config_method_strap_bit2_i,
                      config_method_strap_bit1_i,
                      config_method_strap_bit0_i};

  // capture happens in the first cycle after reset falls, so the pins
  // are sampled at release rather than under reset
  always_comb
  begin
    st_next  = st_reg;
    latch_en = 1'b0;
    run_en   = 1'b0;
    case (st_reg)
      hcs_pkg::HCS_ST_RESET:
      begin
        st_next  = hcs_pkg::HCS_ST_LATCH;
        latch_en = 1'b1;
      end
      hcs_pkg::HCS_ST_LATCH:
      begin
        st_next = hcs_pkg::HCS_ST_RUN;
        run_en  = 1'b1;
      end
      hcs_pkg::HCS_ST_RUN:
      begin
        st_next = hcs_pkg::HCS_ST_RUN;
        run_en  = 1'b1;
      end
      default:
      begin
        st_next = hcs_pkg::HCS_ST_RESET;
      end
    endcase
  end

  // reserved codes fall back to the plain default set
  always_comb
  begin
    eff_sel = strap_sel;
    if (strap_sel > hcs_pkg::SEL_DEFAULT_4WE2)
    begin
      eff_sel = hcs_pkg::SEL_DEFAULT_3W;
    end
  end

  always_comb
  begin
    sel_next      = sel_reg;
    src_next      = src_reg;
    pa_next       = pa_reg;
    led_next      = led_reg;
    strap_en_next = strap_en_reg;
    strap_next    = strap_reg;
    ua_next       = ua_reg;
    master_next   = master_reg;
    slave_next    = slave_reg;
    if (latch_en)
    begin
      sel_next      = strap_sel;
      src_next      = hcs_pkg::HCS_SRC_INTERNAL;
      pa_next       = hcs_pkg::HCS_PA_3WIRE;
      led_next      = hcs_pkg::HCS_LED_USB;
      strap_en_next = 1'b1;
      ua_next       = 1'b0;
      master_next   = 1'b0;
      slave_next    = 1'b0;
      case (eff_sel)
        hcs_pkg::SEL_DEFAULT_3W:
        begin
          pa_next = hcs_pkg::HCS_PA_3WIRE;
        end
        hcs_pkg::SEL_SMBUS:
        begin
          src_next      = hcs_pkg::HCS_SRC_SMBUS;
          strap_en_next = 1'b0;
          led_next      = hcs_pkg::HCS_LED_EXTERNAL;
          slave_next    = 1'b1;
        end
        hcs_pkg::SEL_DEFAULT_4WL:
        begin
          pa_next = hcs_pkg::HCS_PA_4W_LEVEL;
        end
        hcs_pkg::SEL_EEPROM:
        begin
          src_next    = hcs_pkg::HCS_SRC_EEPROM;
          led_next    = hcs_pkg::HCS_LED_EXTERNAL;
          master_next = 1'b1;
        end
        hcs_pkg::SEL_DEFAULT_4WE1:
        begin
          pa_next  = hcs_pkg::HCS_PA_4W_EDGE;
          led_next = hcs_pkg::HCS_LED_SINGLE8;
          ua_next  = 1'b1;
        end
        hcs_pkg::SEL_DEFAULT_4WE2:
        begin
          pa_next       = hcs_pkg::HCS_PA_4W_EDGE;
          led_next      = hcs_pkg::HCS_LED_DUAL8;
          strap_en_next = 1'b0;
          ua_next       = 1'b1;
        end
        default:
        begin
          pa_next = hcs_pkg::HCS_PA_3WIRE;
        end
      endcase
      // straps only kept when the mode samples them
      if (strap_en_next)
      begin
        strap_next = port_led_strap_pins_i;
      end
      else
      begin
        strap_next = '0;
      end
    end
  end

  // self power level tracked continuously once running
  always_comb
  begin
    pwr_next = pwr_reg;
    if (run_en)
    begin
      pwr_next = local_power_detect_i;
    end
  end

  // valid looks one state ahead so the registered copy rises together
  // with the run state; the address is registered only so that every
  // output leaves a flip-flop, it never changes
  always_comb
  begin
    valid_next = (st_next == hcs_pkg::HCS_ST_RUN);
    addr_next  = hcs_pkg::SMB_SLAVE_ADDR;
  end

  // 3-wire mode masks off the top assignment line
  always_comb
  begin
    if (pa_reg == hcs_pkg::HCS_PA_3WIRE)
    begin
      pa_mask = hcs_pkg::PA_WIDTH_3W_MASK;
    end
    else
    begin
      pa_mask = hcs_pkg::PA_WIDTH_4W_MASK;
    end
    pa_raw = port_owner_select_inputs_i & pa_mask;
  end

  // assignment inputs only registered once out of reset
  hcs_sync_reg #(
    .WIDTH (4)
  ) u_assign (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .en_i   (run_en),
    .d_i    (pa_raw),
    .q_o    (port_assign_o)
  );

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      st_reg       <= hcs_pkg::HCS_ST_RESET;
      sel_reg      <= '0;
      src_reg      <= hcs_pkg::HCS_SRC_INTERNAL;
      pa_reg       <= hcs_pkg::HCS_PA_3WIRE;
      led_reg      <= hcs_pkg::HCS_LED_USB;
      strap_en_reg <= 1'b0;
      strap_reg    <= '0;
      ua_reg       <= 1'b0;
      master_reg   <= 1'b0;
      slave_reg    <= 1'b0;
      pwr_reg      <= 1'b0;
      valid_reg    <= 1'b0;
      addr_reg     <= hcs_pkg::SMB_SLAVE_ADDR;
    end
    else
    begin
      st_reg       <= st_next;
      sel_reg      <= sel_next;
      src_reg      <= src_next;
      pa_reg       <= pa_next;
      led_reg      <= led_next;
      strap_en_reg <= strap_en_next;
      strap_reg    <= strap_next;
      ua_reg       <= ua_next;
      master_reg   <= master_next;
      slave_reg    <= slave_next;
      pwr_reg      <= pwr_next;
      valid_reg    <= valid_next;
      addr_reg     <= addr_next;
    end
  end

  // mclk_i stands in for the 24 MHz reference-derived core clock
  assign cfg_sel_o          = sel_reg;
  assign cfg_src_o          = src_reg;
  assign assign_mode_o      = pa_reg;
  assign led_mode_o         = led_reg;
  assign led_strap_en_o     = strap_en_reg;
  assign led_strap_o        = strap_reg;
  assign unassigned_ok_o    = ua_reg;
  assign self_powered_o     = pwr_reg;
  assign cfg_valid_o        = valid_reg;
  assign serial_is_master_o = master_reg;
  assign serial_is_slave_o  = slave_reg;
  // constant address, only meaningful while slave role is set
  assign smb_addr_o         = addr_reg;
endmodule

// ===== tb/hcs_strap_select_checker.sv
/* checker for hcs_strap_select: strap latching and mode decode.
   assumes it is bound to the design and sees only its ports. */
`timescale 1ns/1ps
module hcs_strap_select_checker (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_i,
  // board inputs
  input wire logic       config_method_strap_bit0_i,
  input wire logic       config_method_strap_bit1_i,
  input wire logic       config_method_strap_bit2_i,
  input wire logic [3:0] port_owner_select_inputs_i,
  input wire logic       local_power_detect_i,
  // configuration outputs
  input wire logic [2:0] cfg_sel_o,
  input wire logic [2:0] cfg_src_o,
  input wire logic [2:0] assign_mode_o,
  input wire logic [3:0] led_mode_o,
  input wire logic       led_strap_en_o,
  input wire logic [3:0] led_strap_o,
  input wire logic       unassigned_ok_o,
  input wire logic [3:0] port_assign_o,
  input wire logic       self_powered_o,
  input wire logic       cfg_valid_o,
  input wire logic       serial_is_master_o,
  input wire logic       serial_is_slave_o,
  input wire logic [6:0] smb_addr_o
);
  wire logic [2:0] pin_sel = {config_method_strap_bit2_i,
    config_method_strap_bit1_i, config_method_strap_bit0_i};
  wire logic [2:0] sel = cfg_sel_o;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  chk_sel_latch: assert property ($past(rst_i, 2) && !$past(rst_i)
    |-> sel == $past(pin_sel)) else $error("select not latched");
  // later strap moves must not disturb a running hub
  chk_sel_hold: assert property (!$past(rst_i, 2) && !$past(rst_i)
    |-> $stable(sel) && $stable(cfg_src_o) && $stable(led_mode_o))
    else $error("modes moved after release");
  chk_mode_dflt: assert property (cfg_valid_o && (sel == 3'h0
    || sel[2:1] == 2'b11) |-> cfg_src_o == 3'h1 && assign_mode_o == 3'h1
    && led_mode_o == 4'h1 && led_strap_en_o) else $error("default mode");
  chk_smb_slave: assert property (cfg_valid_o && sel == 3'h1
    |-> cfg_src_o == 3'h2 && serial_is_slave_o && !serial_is_master_o
    && !led_strap_en_o && led_strap_o == 4'h0 && smb_addr_o == 7'h2C)
    else $error("slave mode");
  chk_level_four: assert property (cfg_valid_o && sel == 3'h2
    |-> assign_mode_o == 3'h2 && !unassigned_ok_o && led_mode_o == 4'h1
    && led_strap_en_o) else $error("level mode");
  chk_eeprom_master: assert property (cfg_valid_o && sel == 3'h3
    |-> cfg_src_o == 3'h4 && serial_is_master_o && !serial_is_slave_o)
    else $error("eeprom mode");
  chk_edge_single: assert property (cfg_valid_o && sel == 3'h4
    |-> assign_mode_o == 3'h4 && led_mode_o == 4'h2 && led_strap_en_o
    && unassigned_ok_o) else $error("edge single mode");
  chk_edge_dual: assert property (cfg_valid_o && sel == 3'h5
    |-> assign_mode_o == 3'h4 && led_mode_o == 4'h4 && !led_strap_en_o
    && unassigned_ok_o) else $error("edge dual mode");
  chk_input_track: assert property (cfg_valid_o && $past(cfg_valid_o)
    |-> self_powered_o == $past(local_power_detect_i) && port_assign_o ==
    ($past(port_owner_select_inputs_i) & (assign_mode_o == 3'h1 ? 4'h7
    : 4'hF))) else $error("inputs not tracked");
  chk_reset_quiet: assert property ($past(rst_i)
    |-> port_assign_o == 4'h0 && !cfg_valid_o) else $error("busy in reset");

  cover property (cfg_valid_o && sel == 3'h1);
  cover property (cfg_valid_o && sel == 3'h3);
  cover property (cfg_valid_o && sel == 3'h7);
endmodule

bind hcs_strap_select hcs_strap_select_checker u_hcs_strap_select_checker (.*);

// ===== tb/hcs_board_model.sv
/* hcs_board_model: strap resistors on the select pins.
   assumes the bench picks the strapped value; pins follow it at once. */
`timescale 1ns/1ps
module hcs_board_model (
  // strap choice
  input  wire logic [2:0] strap_i,
  // select pins
  output      logic       bit0_o,
  output      logic       bit1_o,
  output      logic       bit2_o
);
  // resistors are static, so no clock; bit2 is the msb
  assign {bit2_o, bit1_o, bit0_o} = strap_i;
endmodule

// ===== tb/hcs_strap_select_test.sv
/* hcs_strap_select_test: every select code through a reset, then
   mode, latching and input tracking checks.
   assumes straps are sampled on the first edge out of reset. */
`timescale 1ns/1ps
module hcs_strap_select_test;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        config_method_strap_bit0_i;
  logic        config_method_strap_bit1_i;
  logic        config_method_strap_bit2_i;
  logic [3:0]  port_led_strap_pins_i = 4'h0;
  logic [3:0]  port_owner_select_inputs_i = 4'h0;
  logic        local_power_detect_i = 1'b0;
  logic [2:0]  cfg_sel_o, cfg_src_o, assign_mode_o;
  logic [3:0]  led_mode_o, led_strap_o, port_assign_o;
  logic        led_strap_en_o, unassigned_ok_o, self_powered_o;
  logic        cfg_valid_o, serial_is_master_o, serial_is_slave_o;
  logic [6:0]  smb_addr_o;
  logic [2:0]  strap = 3'h0;
  integer      seed = 32'h855d06a3;
  int          miscompares = 0;
  int          tests_run = 0;
  wire logic [13:0] got = {cfg_src_o, assign_mode_o, led_mode_o,
    led_strap_en_o, unassigned_ok_o, serial_is_master_o, serial_is_slave_o};

  hcs_strap_select u_hcs_strap_select (.*);
  hcs_board_model u_hcs_board_model (
    .strap_i (strap),
    .bit0_o  (config_method_strap_bit0_i),
    .bit1_o  (config_method_strap_bit1_i),
    .bit2_o  (config_method_strap_bit2_i)
  );

  always #2.5 mclk_i = ~mclk_i;

  // {mask, expected}; masked fields come from a download, not straps, except unassigned_ok_o in the default set
  function automatic logic [27:0] modes(input logic [2:0] s);
    case (s)
      3'h1:    modes = {14'h38FB, 3'h2, 3'h0, 4'h8, 4'b0001};
      3'h2:    modes = {14'h3FFF, 3'h1, 3'h2, 4'h1, 4'b1000};
      3'h3:    modes = {14'h38F3, 3'h4, 3'h0, 4'h8, 4'b0010};
      3'h4:    modes = {14'h3FFF, 3'h1, 3'h4, 4'h2, 4'b1100};
      3'h5:    modes = {14'h3FFF, 3'h1, 3'h4, 4'h4, 4'b0100};
      default: modes = {14'h3FFB, 3'h1, 3'h1, 4'h1, 4'b1000};
    endcase
  endfunction

  // masked compare of the packed mode outputs against an expectation
  function automatic logic ok_modes(input logic [27:0] e);
    ok_modes = ((got ^ e[13:0]) & e[27:14]) === 14'h0;
  endfunction

  task automatic check(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  task automatic test_done;
    $display("compares %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic run_sel(input logic [2:0] s);
    logic [27:0] em;
    logic [4:0]  pa;
    logic [3:0]  pm;
    logic [3:0]  lx;
    int          n;
    em = modes(s);
    pm = em[22] ? (em[8] ? 4'h7 : 4'hF) : 4'h0;
    @(posedge mclk_i);
    rst_i <= 1'b1;
    strap <= s;
    port_led_strap_pins_i <= $random(seed);
    repeat (hcs_pkg::RESET_MIN_CYC)
    begin
      @(posedge mclk_i);
      port_owner_select_inputs_i <= $random(seed);
    end
    #1 check(port_assign_o === 4'h0, "assign moved in reset");
    @(posedge mclk_i);
    rst_i <= 1'b0;
    n = 0;
    while (cfg_valid_o !== 1'b1 && n < 8)
    begin
      @(posedge mclk_i);
      #1 n++;
    end
    if (n == 8)
    begin
      check(1'b0, "valid never rose");
      test_done();
    end
    check(cfg_sel_o === s, "select");
    check(ok_modes(em), "modes");
    check(smb_addr_o === 7'h2C, "slave address");
    lx = em[3] ? port_led_strap_pins_i : 4'h0;
    if (em[17])
      check(led_strap_o === lx, "leds");
    // straps wander while running; outputs must not follow them
    repeat (12)
    begin
      @(posedge mclk_i);
      strap <= $random(seed);
      pa = $random(seed);
      port_owner_select_inputs_i <= pa[3:0];
      local_power_detect_i <= pa[4];
      @(posedge mclk_i);
      #1 check(self_powered_o === pa[4], "power");
      if (pm !== 4'h0)
        check(port_assign_o === (pa[3:0] & pm), "assign");
    end
    check(cfg_sel_o === s, "select held");
    check(ok_modes(em), "modes held");
    $display("select %0d done", s);
  endtask

  initial
  begin
    repeat (10) @(posedge mclk_i);
    for (int s = 0; s < 8; s++)
      run_sel(s[2:0]);
    run_sel(3'h5);
    test_done();
  end
endmodule
